// ### src/hs_switch_consts.svh
`ifndef HS_SWITCH_CONSTS_SVH
`define HS_SWITCH_CONSTS_SVH
// serial command layout
`define CMD_BITS 8
`define CMD_OP_MSB 7
`define CMD_OP_LSB 4
`define CMD_ARG_MSB 3
`define CMD_ARG_LSB 0
// opcodes
`define OP_SENSE 4'h1
`define OP_OUTPUT 4'h2
`define OP_DIRECT 4'h3
`define OP_OVERCURRENT 4'h4
`define OP_WATCHDOG 4'h5
// argument fields
`define SENSE_CH_BIT 0
`define SENSE_HIZ_BIT 1
`define OC_LOW_LSB 0
`define OC_LOW_MSB 1
// reset values
`define CFG_RESET 4'h0
`define FAULT_RESET 2'h0
// timing, cycles derived from these and the 100 ns clock
`define CLK_PERIOD_NS 100
`define HIGH_BLANK_US 10
`define WDOG_MS 620
`endif

// ### src/hs_switch_pkg.sv
package hs_switch_pkg;
    typedef enum logic [1:0] {
        mode_sleep,
        mode_normal,
        mode_fault,
        mode_failsafe
    } mode_e;
    typedef logic [3:0] cfg_t;
endpackage

// ### src/sync2.sv
`timescale 1ns/10ps
module sync2 #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // async in, synced out
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    always_comb begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;
endmodule // sync2

// ### src/hs_switch_ctrl.sv
`timescale 1ns/10ps
`include "hs_switch_consts.svh"
// Contract
// - current sense reports exactly one output, chosen over the serial link.
// - current sense is high impedance when the link config asks or in sleep, driven otherwise.
// - the watchdog runs only while wake is high.
// - while reset pin is low, config and fault state clear; the device sleeps only if wake is also low.
// - the watchdog restarts on the rising edge of the reset pin.
// - direct input n drives high-side output n.
// - the direct inputs' effect is configured over the serial link.
// - severe overcurrent trips at once, even during high blanking; low level detected after.
// - commands are 8 bits msb first, captured on rising serial clock.
// - serial out is high impedance while deselected, changes on rising clock.
// - wake and reset both low means sleep with all outputs off.
module hs_switch_ctrl #(
    parameter int WDOG_CYCLES = (`WDOG_MS * 1000000) / `CLK_PERIOD_NS,
    parameter int HIGH_BLANK_CYCLES = (`HIGH_BLANK_US * 1000) / `CLK_PERIOD_NS
) (
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // device control pins
    input wire logic reset_pin_n,
    input wire logic wake,
    input wire logic [1:0] direct_control_input,
    // serial link
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic si,
    output logic so_out,
    output logic so_oe,
    // analog front end status
    input wire logic [1:0] over_severe,
    input wire logic [1:0] over_low,
    // outputs
    output logic [1:0] high_side_output,
    output logic sense_select,
    output logic current_sense_oe,
    output logic [1:0] low_overcurrent_level,
    output logic [1:0] fault,
    output logic watchdog_timeout,
    output logic sleep
);
    // blanking counter is 16 bits wide
    if (WDOG_CYCLES < 2 || HIGH_BLANK_CYCLES < 1 || HIGH_BLANK_CYCLES > 16'hffff) begin : g_bad
        $error("bad timing parameters");
    end

    logic rst_s, wake_s, sclk_s, cs_s, sel_s, si_s;
    logic [1:0] din_s;
    sync2 #(.WIDTH(7)) u_sync (
        .clock(clock),
        .resetn(resetn),
        // select enters inverted so the synced reset value reads as deselected
        .async_in({reset_pin_n, wake, sclk, ~cs_n, si, direct_control_input}),
        .sync_out({rst_s, wake_s, sclk_s, sel_s, si_s, din_s})
    );
    assign cs_s = !sel_s;

    // edge detection state
    logic sclk_prev_q, sclk_prev_d, rst_prev_q, rst_prev_d;
    logic sclk_rise, rst_rise;
    assign sclk_rise = sclk_s && !sclk_prev_q;
    assign rst_rise = rst_s && !rst_prev_q;

    // serial shift state
    logic [`CMD_BITS-1:0] shift_q, shift_d, out_q, out_d;
    logic [2:0] bitcnt_q, bitcnt_d;
    logic so_q, so_d;
    // configuration
    logic sense_ch_q, sense_ch_d, sense_hiz_q, sense_hiz_d;
    hs_switch_pkg::cfg_t out_on_q, out_on_d, direct_en_q, direct_en_d, oc_q, oc_d;
    logic [1:0] fault_q, fault_d;
    // blanking and watchdog
    logic [1:0] on_prev_q, on_prev_d;
    logic [15:0] blank_q [2];
    logic [15:0] blank_d [2];
    logic [31:0] wd_q, wd_d;
    logic wdto_q, wdto_d;
    logic [1:0] hs_q, hs_d;
    hs_switch_pkg::mode_e mode;
    logic cmd_done;
    logic [`CMD_BITS-1:0] cmd;
    logic [1:0] want_on;

    assign cmd = {shift_q[`CMD_BITS-2:0], si_s};
    assign cmd_done = sclk_rise && !cs_s && bitcnt_q == 3'h7;

    always_comb begin
        if (!rst_s && !wake_s)
            mode = hs_switch_pkg::mode_sleep;
        else if (wdto_q)
            mode = hs_switch_pkg::mode_failsafe;
        else if (fault_q != `FAULT_RESET)
            mode = hs_switch_pkg::mode_fault;
        else
            mode = hs_switch_pkg::mode_normal;
    end

    always_comb begin
        sclk_prev_d = sclk_s;
        rst_prev_d = rst_s;
        shift_d = shift_q;
        bitcnt_d = bitcnt_q;
        out_d = out_q;
        so_d = so_q;
        sense_ch_d = sense_ch_q;
        sense_hiz_d = sense_hiz_q;
        out_on_d = out_on_q;
        direct_en_d = direct_en_q;
        oc_d = oc_q;
        fault_d = fault_q;
        if (cs_s) begin
            bitcnt_d = '0;
            out_d = {6'h00, fault_q};
            // msb must already stand before the first rising clock
            so_d = out_d[`CMD_BITS-1];
        end else if (sclk_rise) begin
            shift_d = cmd;
            bitcnt_d = bitcnt_q + 3'h1;
            so_d = out_q[`CMD_BITS-2];
            out_d = {out_q[`CMD_BITS-2:0], 1'b0};
        end
        if (cmd_done) begin
            case (cmd[`CMD_OP_MSB:`CMD_OP_LSB])
                `OP_SENSE: begin
                    sense_ch_d = cmd[`SENSE_CH_BIT];
                    sense_hiz_d = cmd[`SENSE_HIZ_BIT];
                end
                `OP_OUTPUT: out_on_d = cmd[`CMD_ARG_MSB:`CMD_ARG_LSB];
                `OP_DIRECT: direct_en_d = cmd[`CMD_ARG_MSB:`CMD_ARG_LSB];
                `OP_OVERCURRENT: oc_d = cmd[`CMD_ARG_MSB:`CMD_ARG_LSB];
                default: ;
            endcase
        end
        for (int i = 0; i < 2; i++) begin
            // severe level trips whenever the output is on; low level only once blanking ends
            if (hs_q[i] && (over_severe[i] || (over_low[i] && blank_q[i] == 16'h0000)))
                fault_d[i] = 1'b1;
        end
        if (!rst_s) begin
            // config and faults cleared while reset pin low
            sense_ch_d = 1'b0;
            sense_hiz_d = 1'b0;
            out_on_d = `CFG_RESET;
            direct_en_d = `CFG_RESET;
            oc_d = `CFG_RESET;
            fault_d = `FAULT_RESET;
        end
    end

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            // direct input n steers output n when enabled for it
            want_on[i] = direct_en_q[i] ? din_s[i] : out_on_q[i];
        end
        on_prev_d = want_on;
        for (int i = 0; i < 2; i++) begin
            if (want_on[i] && !on_prev_q[i])
                blank_d[i] = HIGH_BLANK_CYCLES[15:0];
            else if (blank_q[i] != 16'h0000)
                blank_d[i] = blank_q[i] - 16'h0001;
            else
                blank_d[i] = blank_q[i];
        end
        case (mode)
            hs_switch_pkg::mode_sleep: hs_d = 2'b00;
            hs_switch_pkg::mode_failsafe: hs_d = 2'b00;
            hs_switch_pkg::mode_fault: hs_d = want_on & ~fault_q;
            default: hs_d = want_on;
        endcase
        wd_d = wd_q;
        wdto_d = wdto_q;
        if (!rst_s || rst_rise || cmd_done) begin
            wd_d = '0;
            if (rst_rise)
                wdto_d = 1'b0;
        end else if (wake_s && !wdto_q) begin
            // watchdog counts only with wake high
            if (wd_q == WDOG_CYCLES - 1)
                wdto_d = 1'b1;
            else
                wd_d = wd_q + 32'h1;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            sclk_prev_q <= 1'b0;
            rst_prev_q <= 1'b0;
            shift_q <= '0;
            bitcnt_q <= '0;
            out_q <= '0;
            so_q <= 1'b0;
            sense_ch_q <= 1'b0;
            sense_hiz_q <= 1'b0;
            out_on_q <= `CFG_RESET;
            direct_en_q <= `CFG_RESET;
            oc_q <= `CFG_RESET;
            fault_q <= `FAULT_RESET;
            on_prev_q <= 2'b00;
            blank_q[0] <= 16'h0000;
            blank_q[1] <= 16'h0000;
            wd_q <= '0;
            wdto_q <= 1'b0;
            hs_q <= 2'b00;
        end else begin
            sclk_prev_q <= sclk_prev_d;
            rst_prev_q <= rst_prev_d;
            shift_q <= shift_d;
            bitcnt_q <= bitcnt_d;
            out_q <= out_d;
            so_q <= so_d;
            sense_ch_q <= sense_ch_d;
            sense_hiz_q <= sense_hiz_d;
            out_on_q <= out_on_d;
            direct_en_q <= direct_en_d;
            oc_q <= oc_d;
            fault_q <= fault_d;
            on_prev_q <= on_prev_d;
            blank_q[0] <= blank_d[0];
            blank_q[1] <= blank_d[1];
            wd_q <= wd_d;
            wdto_q <= wdto_d;
            hs_q <= hs_d;
        end
    end

    assign so_out = so_q;
    assign so_oe = !cs_s;
    assign high_side_output = hs_q;
    assign sense_select = sense_ch_q;
    assign current_sense_oe = !sense_hiz_q && !sleep;
    assign low_overcurrent_level = oc_q[`OC_LOW_MSB:`OC_LOW_LSB];
    assign fault = fault_q;
    assign watchdog_timeout = wdto_q;
    assign sleep = mode == hs_switch_pkg::mode_sleep;

    sequence s_cfg_cmd;
        cmd_done && cmd[`CMD_OP_MSB:`CMD_OP_LSB] == `OP_SENSE && rst_s;
    endsequence
    property p_sense_sel;
        @(posedge clock) disable iff (!resetn)
        s_cfg_cmd |=> sense_select == $past(cmd[`SENSE_CH_BIT]);
    endproperty
    a_sense_sel: assert property (p_sense_sel) else $error("sense select not loaded");
    property p_sense_hiz;
        @(posedge clock) disable iff (!resetn)
        s_cfg_cmd |=> current_sense_oe == (!$past(cmd[`SENSE_HIZ_BIT]) && !sleep);
    endproperty
    a_sense_hiz: assert property (p_sense_hiz) else $error("sense driven in hiz");
    property p_wd_wake;
        @(posedge clock) disable iff (!resetn)
        !wake_s && rst_s && !rst_rise && !cmd_done |=> wd_q == $past(wd_q);
    endproperty
    a_wd_wake: assert property (p_wd_wake) else $error("watchdog ran without wake");
    property p_rst_clear;
        @(posedge clock) disable iff (!resetn)
        !rst_s |=> fault == 2'b00 && direct_en_q == 4'h0 && out_on_q == 4'h0;
    endproperty
    a_rst_clear: assert property (p_rst_clear) else $error("reset pin left state");
    property p_wd_start;
        @(posedge clock) disable iff (!resetn)
        rst_rise |=> wd_q == 32'h0 && !watchdog_timeout;
    endproperty
    a_wd_start: assert property (p_wd_start) else $error("watchdog not restarted");
    property p_direct;
        @(posedge clock) disable iff (!resetn)
        direct_en_q[0] && mode == hs_switch_pkg::mode_normal |=> high_side_output[0] == $past(din_s[0]);
    endproperty
    a_direct: assert property (p_direct) else $error("direct input ignored");
    property p_so_hiz;
        @(posedge clock) disable iff (!resetn)
        cs_n[*3] |-> !so_oe;
    endproperty
    a_so_hiz: assert property (p_so_hiz) else $error("so driven while deselected");
    property p_sleep_off;
        @(posedge clock) disable iff (!resetn)
        (!rst_s && !wake_s)[*2] |-> high_side_output == 2'b00;
    endproperty
    a_sleep_off: assert property (p_sleep_off) else $error("output on in sleep");
endmodule // hs_switch_ctrl

// ### tb/host_model.sv
`timescale 1ns/10ps
module host_model (
    // clock
    input wire logic clock,
    // device pins
    output logic reset_pin_n,
    output logic wake,
    output logic sclk,
    output logic cs_n,
    output logic si,
    input wire logic so_out,
    input wire logic so_oe
);
    initial begin
        reset_pin_n = 1'b0;
        wake = 1'b0;
        sclk = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic hold_reset(input logic wk);
        wake = wk;
        reset_pin_n = 1'b0;
        tick(6);
    endtask
    // supply is taken as good here, so release follows the low width
    task automatic release_reset();
        reset_pin_n = 1'b1;
        tick(50);
    endtask
    task automatic send(input logic [7:0] cmd, output logic [7:0] rd);
        cs_n = 1'b0;
        tick(4);
        for (int i = 7; i >= 0; i--) begin
            si = cmd[i];
            tick(4);
            // an undriven data line reads as the inverse of the last bit
            rd[i] = so_oe ? so_out : !so_out;
            sclk = 1'b1;
            tick(4);
            sclk = 1'b0;
        end
        tick(4);
        cs_n = 1'b1;
        // si has a pull-down, so released it reads low
        si = 1'b0;
        tick(4);
    endtask
endmodule // host_model

// ### tb/highside_switch_control_pins_test.sv
`timescale 1ns/10ps
`define CHK(got, exp) \
    begin \
        n_checks++; \
        if ((got) !== (exp)) begin \
            failures++; \
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp); \
        end \
    end
module highside_switch_control_pins_test;
    logic clock, resetn, sclk, cs_n, si, so_out, so_oe, reset_pin_n, wake;
    logic [1:0] direct_control_input, over_severe, over_low, high_side_output;
    logic [1:0] low_overcurrent_level, fault;
    logic sense_select, current_sense_oe, watchdog_timeout, sleep;
    logic [7:0] rd;
    int failures = 0;
    int n_checks = 0;
    int n;
    hs_switch_ctrl #(.WDOG_CYCLES(2000), .HIGH_BLANK_CYCLES(4)) dut (
        .clock(clock), .resetn(resetn), .reset_pin_n(reset_pin_n), .wake(wake),
        .direct_control_input(direct_control_input), .sclk(sclk), .cs_n(cs_n),
        .si(si), .so_out(so_out), .so_oe(so_oe), .over_severe(over_severe),
        .over_low(over_low), .high_side_output(high_side_output),
        .sense_select(sense_select), .current_sense_oe(current_sense_oe),
        .low_overcurrent_level(low_overcurrent_level), .fault(fault),
        .watchdog_timeout(watchdog_timeout), .sleep(sleep)
    );
    host_model host (
        .clock(clock), .reset_pin_n(reset_pin_n), .wake(wake), .sclk(sclk),
        .cs_n(cs_n), .si(si), .so_out(so_out), .so_oe(so_oe)
    );
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    task automatic stop_test();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        resetn = 1'b0;
        direct_control_input = 2'h0;
        over_severe = 2'h0;
        over_low = 2'h0;
        host.tick(16);
        resetn = 1'b1;
        host.tick(3);
        host.release_reset();
        for (int a = 0; a < 4; a++) begin
            host.send({4'h1, 2'h0, 2'(a)}, rd);
            `CHK(sense_select, 1'(a))
            `CHK(current_sense_oe, ~a[1])
        end
        host.send(8'h33, rd);
        host.send(8'h20, rd);
        for (int d = 0; d < 4; d++) begin
            direct_control_input = 2'(d);
            host.tick(5);
            `CHK(high_side_output, 2'(d))
        end
        host.send(8'h30, rd);
        host.tick(5);
        `CHK(high_side_output, 2'h0)
        direct_control_input = 2'h0;
        fork
            host.send(8'h43, rd);
            begin
                host.tick(10);
                `CHK(so_oe, 1'b1)
            end
        join
        `CHK(so_oe, 1'b0)
        `CHK(low_overcurrent_level, 2'h3)
        host.send(8'h21, rd);
        `CHK(high_side_output, 2'h1)
        // severe level held far beyond the blanking window must trip
        over_severe = 2'h1;
        host.tick(20);
        over_severe = 2'h0;
        `CHK(fault, 2'h1)
        `CHK(high_side_output[0], 1'b0)
        host.send(8'h00, rd);
        `CHK(rd, 8'h01)
        host.hold_reset(1'b0);
        `CHK(fault, 2'h0)
        `CHK(low_overcurrent_level, 2'h0)
        `CHK(sense_select, 1'b0)
        `CHK(sleep, 1'b1)
        `CHK(high_side_output, 2'h0)
        host.release_reset();
        // output 1 under direct control, low overcurrent present from turn-on
        host.send(8'h32, rd);
        over_low = 2'h2;
        direct_control_input = 2'h2;
        host.tick(4);
        `CHK(fault, 2'h0)
        `CHK(high_side_output, 2'h2)
        host.tick(5);
        `CHK(fault, 2'h2)
        `CHK(high_side_output, 2'h0)
        over_low = 2'h0;
        direct_control_input = 2'h0;
        host.tick(2100);
        `CHK(watchdog_timeout, 1'b0)
        host.hold_reset(1'b1);
        host.release_reset();
        `CHK(sleep, 1'b0)
        // a bound that runs out leaves n past the window and fails the check
        for (n = 50; n <= 3000 && watchdog_timeout !== 1'b1; n++)
            host.tick(1);
        `CHK(n >= 1990 && n <= 2010, 1'b1)
        // outputs asked on after expiry stay off until the reset pin cycles
        host.send(8'h23, rd);
        `CHK(high_side_output, 2'h0)
        `CHK(watchdog_timeout, 1'b1)
        stop_test();
    end
endmodule // highside_switch_control_pins_test
